// [dv/cfmp_engine_model.sv]
`default_nettype none
module cfmp_engine_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Bench control
  input wire logic [1:0] rxPush,
  input wire logic [1:0] txGo,
  input wire logic [1:0] endKind,
  // Design side
  input wire logic [1:0] txPending,
  output logic [1:0] rxMsgAccept,
  output logic [1:0] txBusy,
  output logic [1:0] txDone,
  output logic [1:0] txBusError,
  output logic [1:0] txArbLost,
  output logic [1:0] haltEntry
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0][4:0] waitCnt;

  // Frame timing per channel; a send ends by success or by one of three stops
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      {rxMsgAccept, txBusy, txDone, txBusError, txArbLost, haltEntry} <= '0;
      waitCnt <= '0;
    end
    else
      for (int c = 0; c < 2; c++)
      begin
        rxMsgAccept[c] <= rxPush[c];
        txDone[c] <= txBusy[c] && waitCnt[c] == 5'h00 && endKind == 2'h0;
        txBusError[c] <= txBusy[c] && waitCnt[c] == 5'h00 && endKind == 2'h1;
        txArbLost[c] <= txBusy[c] && waitCnt[c] == 5'h00 && endKind == 2'h2;
        haltEntry[c] <= txBusy[c] && waitCnt[c] == 5'h00 && endKind == 2'h3;
        if (txBusy[c])
        begin
          waitCnt[c] <= waitCnt[c] - 5'h01;
          txBusy[c] <= waitCnt[c] != 5'h00;
        end
        else if (txGo[c] && txPending[c] && !(txDone[c] || txBusError[c] || txArbLost[c] || haltEntry[c]))
        begin
          txBusy[c] <= 1'b1;
          waitCnt[c] <= 5'h14;
        end
      end
endmodule : cfmp_engine_model
`default_nettype wire

// [dv/cfmp_fifo_ctrl_properties.sv]
`default_nettype none
module cfmp_fifo_ctrl_properties (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Queue side
  input wire logic [1:0] rxMsgAccept,
  input wire logic [1:0] rxQueueEnable,
  input wire logic [3:0] rxWriteSlot,
  input wire logic [3:0] rxReadSlot,
  input wire logic [1:0] txDone,
  input wire logic [1:0] txQueueEnable,
  input wire logic [1:0] txPending,
  input wire logic [3:0] txWriteSlot,
  input wire logic [3:0] txReadSlot
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  chk_tx_wr_step: assert property ($changed(txWriteSlot[1:0]) && txQueueEnable[0] |->
    txWriteSlot[1:0] == $past(txWriteSlot[1:0]) + 2'h1 && $rose(s_axi_bvalid))
    else $error("transmit write slot moved wrongly");
  chk_tx_rd_step: assert property ($changed(txReadSlot[1:0]) && txQueueEnable[0] |->
    $past(txDone[0]) && txReadSlot[1:0] == $past(txReadSlot[1:0]) + 2'h1)
    else $error("transmit read slot moved wrongly");
  chk_rx_wr_step: assert property ($changed(rxWriteSlot[1:0]) && rxQueueEnable[0] |->
    $past(rxMsgAccept[0]) && rxWriteSlot[1:0] == $past(rxWriteSlot[1:0]) + 2'h1)
    else $error("receive write slot moved wrongly");
  chk_rx_rd_step: assert property ($changed(rxReadSlot[1:0]) && rxQueueEnable[0] |->
    ($rose(s_axi_bvalid) || $past(rxMsgAccept[0])) && rxReadSlot[1:0] == $past(rxReadSlot[1:0]) + 2'h1)
    else $error("receive read slot moved wrongly");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  chk_pend_fall: assert property ($fell(txPending[0]) |-> $past(txDone[0]) || $rose(s_axi_bvalid))
    else $error("pending dropped without cause");

  cover property (txDone[0]);
  cover property ($rose(txPending[0]));
  cover property (rxMsgAccept[0] && rxQueueEnable[0]);
endmodule : cfmp_fifo_ctrl_properties
`default_nettype wire

// [dv/tb_top.sv]
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb, rxWriteSlot, rxReadSlot, txWriteSlot, txReadSlot;
  logic [1:0] s_axi_bresp, s_axi_rresp, rxPush, txGo, endKind, rxMsgAccept, rxQueueEnable, txBusy, txDone;
  logic [1:0] txBusError, txArbLost, haltEntry, txQueueEnable, txPending, rr;
  logic [7:0] rv;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;

  cfmp_fifo_ctrl DUT (.ref_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxMsgAccept,
    .rxQueueEnable, .rxWriteSlot, .rxReadSlot, .txBusy, .txDone, .txBusError, .txArbLost, .haltEntry,
    .txQueueEnable, .txPending, .txWriteSlot, .txReadSlot);

  cfmp_engine_model engine (.ref_clk, .resetn, .rxPush, .txGo, .endKind, .txPending, .rxMsgAccept, .txBusy,
    .txDone, .txBusError, .txArbLost, .haltEntry);

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic close_out;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      $display("ERROR %0t timeout", $time);
      close_out();
    end
  end

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic [29:0] a, input logic [7:0] d);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= {a, 2'h0};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w)
    begin
      @(posedge ref_clk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge ref_clk); while (!s_axi_bvalid);
    rr = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [29:0] a);
    s_axi_araddr <= {a, 2'h0};
    s_axi_arvalid <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    rv = s_axi_rdata[7:0];
    rr = s_axi_rresp;
  endtask : rd

  task automatic rdc(input logic [29:0] a, input logic [7:0] exp);
    rd(a);
    cmp(rv, exp);
    cmp({6'h00, rr}, {6'h00, cfmp_pkg::RESP_OKAY});
  endtask : rdc

  task automatic push(input int n);
    repeat (n)
    begin
      rxPush <= 2'h1;
      @(posedge ref_clk);
      rxPush <= 2'h0;
      @(posedge ref_clk);
    end
    @(posedge ref_clk);
  endtask : push

  task automatic t_reset;
    rdc(cfmp_pkg::IDX_TXCTL0, 8'h80);
    rdc(cfmp_pkg::IDX_RXCTL0, 8'h80);
    rd(30'h00000010);
    cmp({6'h00, rr}, {6'h00, cfmp_pkg::RESP_SLVERR});
  endtask : t_reset

  task automatic t_tx_fill;
    wr(cfmp_pkg::IDX_MODE0, 8'h01);
    wr(cfmp_pkg::IDX_TXCTL0, 8'h01);
    cmp({7'h00, txQueueEnable[0]}, 8'h01);
    wr(cfmp_pkg::IDX_TXSTB0, 8'h55);
    cmp({6'h00, txWriteSlot[1:0]}, 8'h00);
    for (int i = 1; i <= 4; i++)
    begin
      wr(cfmp_pkg::IDX_TXSTB0, 8'hFF);
      rdc(cfmp_pkg::IDX_TXCTL0, {1'b0, i == 4, 2'h0, 3'(i), 1'b1});
    end
    cmp({6'h00, txWriteSlot[1:0]}, 8'h00);
  endtask : t_tx_fill

  task automatic t_tx_send;
    endKind <= 2'h0;
    txGo <= 2'h1;
    do @(posedge ref_clk); while (txPending[0]);
    txGo <= 2'h0;
    rdc(cfmp_pkg::IDX_TXCTL0, 8'h81);
    cmp({6'h00, txReadSlot[1:0]}, 8'h00);
  endtask : t_tx_send

  task automatic t_tx_flush;
    for (int k = 0; k < 5; k++)
    begin
      wr(cfmp_pkg::IDX_TXCTL0, 8'h01);
      repeat (4) wr(cfmp_pkg::IDX_TXSTB0, 8'hFF);
      if (k < 4)
      begin
        endKind <= 2'(k);
        txGo <= 2'h1;
        do @(posedge ref_clk); while (!txBusy[0]);
        txGo <= 2'h0;
        wr(cfmp_pkg::IDX_TXCTL0, 8'h00);
        rdc(cfmp_pkg::IDX_TXCTL0, 8'h48);
        do @(posedge ref_clk); while (txBusy[0]);
      end
      else
        wr(cfmp_pkg::IDX_TXCTL0, 8'h00);
      rdc(cfmp_pkg::IDX_TXCTL0, 8'h80);
    end
  endtask : t_tx_flush

  task automatic t_rx;
    wr(cfmp_pkg::IDX_MODE0, 8'h03);
    wr(cfmp_pkg::IDX_RXCTL0, 8'h01);
    push(4);
    rdc(cfmp_pkg::IDX_RXCTL0, 8'h29);
    wr(cfmp_pkg::IDX_RXSTB0, 8'hFF);
    cmp({6'h00, rxReadSlot[1:0]}, 8'h01);
    rdc(cfmp_pkg::IDX_RXCTL0, 8'h47);
    push(2);
    cmp({4'h0, rxWriteSlot[1:0], rxReadSlot[1:0]}, 8'h0A);
    rdc(cfmp_pkg::IDX_RXCTL0, 8'h39);
    wr(cfmp_pkg::IDX_RXSTB0, 8'hFF);
    cmp({6'h00, rxReadSlot[1:0]}, 8'h02);
    wr(cfmp_pkg::IDX_RXCTL0, 8'h00);
    rdc(cfmp_pkg::IDX_RXCTL0, 8'h80);
  endtask : t_rx

  initial
  begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {rxPush, txGo, endKind} = '0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    resetn = 1'b0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_tx_fill();
    t_tx_send();
    t_tx_flush();
    t_rx();
    close_out();
  end
endmodule : tb_top

bind cfmp_fifo_ctrl cfmp_fifo_ctrl_properties chk (.ref_clk, .resetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .rxMsgAccept,
  .rxQueueEnable, .rxWriteSlot, .rxReadSlot, .txDone, .txQueueEnable, .txPending, .txWriteSlot, .txReadSlot);
`default_nettype wire

// [verilog/cfmp_fifo_ctrl.sv]
// Local design decision: the AXI4-Lite slave port.
`default_nettype none
module cfmp_fifo_ctrl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // AXI4-Lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Protocol engine, receive side, one bit per channel, two bits per channel for the slot numbers
  input wire logic [1:0] rxMsgAccept,
  output logic [1:0] rxQueueEnable,
  output logic [3:0] rxWriteSlot,
  output logic [3:0] rxReadSlot,
  // Protocol engine, transmit side, one bit per channel, two bits per channel for the slot numbers
  input wire logic [1:0] txBusy,
  input wire logic [1:0] txDone,
  input wire logic [1:0] txBusError,
  input wire logic [1:0] txArbLost,
  input wire logic [1:0] haltEntry,
  output logic [1:0] txQueueEnable,
  output logic [1:0] txPending,
  output logic [3:0] txWriteSlot,
  output logic [3:0] txReadSlot
);

  // Address decode to channel and register
  function automatic logic [3:0] decode(input logic [31:0] addr);
    logic [29:0] idx;
    idx = addr[31:2];
    unique case (idx)
      cfmp_pkg::IDX_RXCTL0: return {1'b0, cfmp_pkg::SEL_RXCTL};
      cfmp_pkg::IDX_RXSTB0: return {1'b0, cfmp_pkg::SEL_RXSTB};
      cfmp_pkg::IDX_TXCTL0: return {1'b0, cfmp_pkg::SEL_TXCTL};
      cfmp_pkg::IDX_TXSTB0: return {1'b0, cfmp_pkg::SEL_TXSTB};
      cfmp_pkg::IDX_MODE0: return {1'b0, cfmp_pkg::SEL_MODE};
      cfmp_pkg::IDX_RXCTL1: return {1'b1, cfmp_pkg::SEL_RXCTL};
      cfmp_pkg::IDX_RXSTB1: return {1'b1, cfmp_pkg::SEL_RXSTB};
      cfmp_pkg::IDX_TXCTL1: return {1'b1, cfmp_pkg::SEL_TXCTL};
      cfmp_pkg::IDX_TXSTB1: return {1'b1, cfmp_pkg::SEL_TXSTB};
      cfmp_pkg::IDX_MODE1: return {1'b1, cfmp_pkg::SEL_MODE};
      default: return {1'b0, cfmp_pkg::SEL_NONE};
    endcase
  endfunction : decode

  // Write channel state
  logic awHeldQ, awHeldD, wHeldQ, wHeldD;
  logic [31:0] awAddrQ, awAddrD;
  logic [7:0] wByteQ, wByteD;
  logic wLane0Q, wLane0D;
  logic awreadyQ, awreadyD, wreadyQ, wreadyD;
  logic bvalidQ, bvalidD;
  logic [1:0] brespQ, brespD;
  // Read channel state
  logic arreadyQ, arreadyD, rvalidQ, rvalidD;
  logic [1:0] rrespQ, rrespD;
  logic [31:0] rdataQ, rdataD;
  // Mode bits per channel
  logic [1:0] modeQ [2], modeD [2];
  // Per-channel write pulses and status
  logic doWrite;
  logic [3:0] wrSel, rdSel;
  logic [1:0] rxCtlWr, rxStbWr, txCtlWr, txStbWr;
  logic [7:0] rxStatus [2], txStatus [2];
  logic [1:0] rxLost;

  always_comb
  begin
    awHeldD = awHeldQ;
    awAddrD = awAddrQ;
    wHeldD = wHeldQ;
    wByteD = wByteQ;
    wLane0D = wLane0Q;
    bvalidD = bvalidQ;
    brespD = brespQ;
    modeD = modeQ;
    rxCtlWr = 2'h0;
    rxStbWr = 2'h0;
    txCtlWr = 2'h0;
    txStbWr = 2'h0;
    if (s_axi_awvalid && awreadyQ)
    begin
      awHeldD = 1'b1;
      awAddrD = s_axi_awaddr;
    end
    if (s_axi_wvalid && wreadyQ)
    begin
      wHeldD = 1'b1;
      wByteD = s_axi_wdata[7:0];
      wLane0D = s_axi_wstrb[0];
    end
    wrSel = decode(awAddrQ);
    doWrite = awHeldQ && wHeldQ && !bvalidQ;
    if (doWrite)
    begin
      awHeldD = 1'b0;
      wHeldD = 1'b0;
      bvalidD = 1'b1;
      brespD = (wrSel[2:0] == cfmp_pkg::SEL_NONE) ? cfmp_pkg::RESP_SLVERR : cfmp_pkg::RESP_OKAY;
      if (wLane0Q)
      begin
        unique case (wrSel[2:0])
          cfmp_pkg::SEL_RXCTL: rxCtlWr[wrSel[3]] = 1'b1;
          cfmp_pkg::SEL_RXSTB: rxStbWr[wrSel[3]] = 1'b1;
          cfmp_pkg::SEL_TXCTL: txCtlWr[wrSel[3]] = 1'b1;
          cfmp_pkg::SEL_TXSTB: txStbWr[wrSel[3]] = 1'b1;
          cfmp_pkg::SEL_MODE: modeD[wrSel[3]] = wByteQ[1:0];
          default: modeD = modeQ;
        endcase
      end
    end
    if (bvalidQ && s_axi_bready)
    begin
      bvalidD = 1'b0;
    end
    awreadyD = !awHeldD && !bvalidD;
    wreadyD = !wHeldD && !bvalidD;
  end

  always_comb
  begin
    rvalidD = rvalidQ;
    rrespD = rrespQ;
    rdataD = rdataQ;
    rdSel = decode(s_axi_araddr);
    if (rvalidQ && s_axi_rready)
    begin
      rvalidD = 1'b0;
    end
    if (s_axi_arvalid && arreadyQ)
    begin
      rvalidD = 1'b1;
      rrespD = cfmp_pkg::RESP_OKAY;
      rdataD = 32'h00000000;
      unique case (rdSel[2:0])
        cfmp_pkg::SEL_RXCTL: rdataD[7:0] = rxStatus[rdSel[3]];
        cfmp_pkg::SEL_TXCTL: rdataD[7:0] = txStatus[rdSel[3]];
        cfmp_pkg::SEL_MODE: rdataD[1:0] = modeQ[rdSel[3]];
        cfmp_pkg::SEL_NONE: rrespD = cfmp_pkg::RESP_SLVERR;
        default: rdataD = 32'h00000000;
      endcase
    end
    arreadyD = !rvalidD;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      awHeldQ <= 1'b0;
      awAddrQ <= 32'h00000000;
      wHeldQ <= 1'b0;
      wByteQ <= 8'h00;
      wLane0Q <= 1'b0;
      awreadyQ <= 1'b1;
      wreadyQ <= 1'b1;
      bvalidQ <= 1'b0;
      brespQ <= 2'h0;
      arreadyQ <= 1'b1;
      rvalidQ <= 1'b0;
      rrespQ <= 2'h0;
      rdataQ <= 32'h00000000;
      modeQ[0] <= cfmp_pkg::MODE_RESET;
      modeQ[1] <= cfmp_pkg::MODE_RESET;
    end
    else
    begin
      awHeldQ <= awHeldD;
      awAddrQ <= awAddrD;
      wHeldQ <= wHeldD;
      wByteQ <= wByteD;
      wLane0Q <= wLane0D;
      awreadyQ <= awreadyD;
      wreadyQ <= wreadyD;
      bvalidQ <= bvalidD;
      brespQ <= brespD;
      arreadyQ <= arreadyD;
      rvalidQ <= rvalidD;
      rrespQ <= rrespD;
      rdataQ <= rdataD;
      modeQ <= modeD;
    end
  end

  // One receive and one transmit queue per channel
  for (genvar c = 0; c < cfmp_pkg::NCH; c++)
  begin : g_ch
    cfmp_rx_queue u_rx (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .ctlWr(rxCtlWr[c]),
      .strobeWr(rxStbWr[c]),
      .wrData(wByteQ),
      .mailboxModeSelect(modeQ[c][cfmp_pkg::F_MAILBOX_MODE]),
      .overwriteMode(modeQ[c][cfmp_pkg::F_OVERWRITE]),
      .statusByte(rxStatus[c]),
      .msgAccept(rxMsgAccept[c]),
      .rxQueueEnable(rxQueueEnable[c]),
      .writeSlot_q(rxLost[c]),
      .writeSlot(rxWriteSlot[2*c+1:2*c]),
      .readSlot(rxReadSlot[2*c+1:2*c])
    );
    cfmp_tx_queue u_tx (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .ctlWr(txCtlWr[c]),
      .strobeWr(txStbWr[c]),
      .wrData(wByteQ),
      .mailboxModeSelect(modeQ[c][cfmp_pkg::F_MAILBOX_MODE]),
      .statusByte(txStatus[c]),
      .txBusy(txBusy[c]),
      .txDone(txDone[c]),
      .txStop(txBusError[c] | txArbLost[c] | haltEntry[c]),
      .txQueueEnable(txQueueEnable[c]),
      .txPending(txPending[c]),
      .writeSlot(txWriteSlot[2*c+1:2*c]),
      .readSlot(txReadSlot[2*c+1:2*c])
    );
  end

  assign s_axi_awready = awreadyQ;
  assign s_axi_wready = wreadyQ;
  assign s_axi_bvalid = bvalidQ;
  assign s_axi_bresp = brespQ;
  assign s_axi_arready = arreadyQ;
  assign s_axi_rvalid = rvalidQ;
  assign s_axi_rresp = rrespQ;
  assign s_axi_rdata = rdataQ;

endmodule : cfmp_fifo_ctrl
`default_nettype wire

// [verilog/cfmp_pkg.sv]
`default_nettype none
package cfmp_pkg;

  // Channels and queue geometry
  localparam int NCH = 2;
  localparam logic [2:0] QUEUE_DEPTH = 3'h4;
  localparam logic [2:0] WARN_LEVEL = 3'h3;

  // Register indices; byte address is four times the index
  localparam logic [29:0] IDX_RXCTL0 = 30'h00047F48;
  localparam logic [29:0] IDX_RXSTB0 = 30'h00047F49;
  localparam logic [29:0] IDX_TXCTL0 = 30'h00047F4A;
  localparam logic [29:0] IDX_TXSTB0 = 30'h00047F4B;
  localparam logic [29:0] IDX_MODE0 = 30'h00047F60;
  localparam logic [29:0] IDX_RXCTL1 = 30'h00047B48;
  localparam logic [29:0] IDX_RXSTB1 = 30'h00047B49;
  localparam logic [29:0] IDX_TXCTL1 = 30'h00047B4A;
  localparam logic [29:0] IDX_TXSTB1 = 30'h00047B4B;
  localparam logic [29:0] IDX_MODE1 = 30'h00047B60;

  // Control register fields
  localparam int F_ENABLE = 0;
  localparam int F_COUNT_LO = 1;
  localparam int F_RX_LOST = 4;
  localparam int F_RX_FULL = 5;
  localparam int F_RX_WARN = 6;
  localparam int F_TX_FULL = 6;
  localparam int F_EMPTY = 7;

  // Mode register fields
  localparam int F_MAILBOX_MODE = 0;
  localparam int F_OVERWRITE = 1;

  // Reset values and codes
  localparam logic [7:0] RXCTL_RESET = 8'h80;
  localparam logic [7:0] TXCTL_RESET = 8'h80;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [7:0] STROBE_CODE = 8'hFF;
  localparam logic [2:0] LOST_GUARD_CYCLES = 3'h5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_RXCTL = 3'b001,
    SEL_RXSTB = 3'b010,
    SEL_TXCTL = 3'b011,
    SEL_TXSTB = 3'b100,
    SEL_MODE = 3'b101
  } cfmp_sel_t;

  // Slot pointer advance, wrapping over four slots
  function automatic logic [1:0] ptr_next(input logic [1:0] p);
    return p + 2'h1;
  endfunction : ptr_next

endpackage : cfmp_pkg
`default_nettype wire

// [verilog/cfmp_rx_queue.sv]
`default_nettype none
module cfmp_rx_queue (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register side
  input wire logic ctlWr,
  input wire logic strobeWr,
  input wire logic [7:0] wrData,
  input wire logic mailboxModeSelect,
  input wire logic overwriteMode,
  output logic [7:0] statusByte,
  // Protocol engine side
  input wire logic msgAccept,
  output logic rxQueueEnable,
  output logic writeSlot_q,
  output logic [1:0] writeSlot,
  output logic [1:0] readSlot
);

  logic enQ, enD;
  logic [2:0] cntQ, cntD;
  logic [1:0] cpuQ, cpuD, canQ, canD;
  logic lostQ, lostD;
  logic [2:0] guardQ, guardD;
  logic full, pop, push, lostSet;

  always_comb
  begin
    enD = enQ;
    cpuD = cpuQ;
    canD = canQ;
    lostD = lostQ;
    guardD = (guardQ != 3'h0) ? guardQ - 3'h1 : guardQ;
    full = (cntQ == cfmp_pkg::QUEUE_DEPTH);
    push = 1'b0;
    lostSet = 1'b0;
    pop = strobeWr && (wrData == cfmp_pkg::STROBE_CODE) && enQ && (cntQ != 3'h0)
      && !(overwriteMode && full && lostQ);
    if (pop)
    begin
      cpuD = cfmp_pkg::ptr_next(cpuQ);
    end
    if (enQ && msgAccept)
    begin
      if (!full || pop)
      begin
        push = 1'b1;
        canD = cfmp_pkg::ptr_next(canQ);
      end
      else
      begin
        lostSet = 1'b1;
        guardD = cfmp_pkg::LOST_GUARD_CYCLES;
        if (overwriteMode)
        begin
          canD = cfmp_pkg::ptr_next(canQ);
          cpuD = cfmp_pkg::ptr_next(cpuQ);
        end
      end
    end
    cntD = cntQ + {2'h0, push} - {2'h0, pop};
    if (ctlWr)
    begin
      enD = wrData[cfmp_pkg::F_ENABLE] && mailboxModeSelect;
      if (!wrData[cfmp_pkg::F_RX_LOST] && (guardQ == 3'h0))
      begin
        lostD = 1'b0;
      end
    end
    if (lostSet)
    begin
      lostD = 1'b1;
    end
    if (!enD)
    begin
      cntD = 3'h0;
      cpuD = canD;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      enQ <= 1'b0;
      cntQ <= 3'h0;
      cpuQ <= 2'h0;
      canQ <= 2'h0;
      lostQ <= 1'b0;
      guardQ <= 3'h0;
    end
    else
    begin
      enQ <= enD;
      cntQ <= cntD;
      cpuQ <= cpuD;
      canQ <= canD;
      lostQ <= lostD;
      guardQ <= guardD;
    end
  end

  assign statusByte = {cntQ == 3'h0, cntQ == cfmp_pkg::WARN_LEVEL, full, lostQ, cntQ, enQ};
  assign rxQueueEnable = enQ;
  assign writeSlot_q = lostQ;
  assign writeSlot = canQ;
  assign readSlot = cpuQ;

endmodule : cfmp_rx_queue
`default_nettype wire

// [verilog/cfmp_tx_queue.sv]
`default_nettype none
module cfmp_tx_queue (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register side
  input wire logic ctlWr,
  input wire logic strobeWr,
  input wire logic [7:0] wrData,
  input wire logic mailboxModeSelect,
  output logic [7:0] statusByte,
  // Protocol engine side
  input wire logic txBusy,
  input wire logic txDone,
  input wire logic txStop,
  output logic txQueueEnable,
  output logic txPending,
  output logic [1:0] writeSlot,
  output logic [1:0] readSlot
);

  logic enQ, enD;
  logic [2:0] cntQ, cntD;
  logic [1:0] cpuQ, cpuD, canQ, canD;
  logic flushQ, flushD;
  logic pendQ, pendD;
  logic push, pop, drop;

  always_comb
  begin
    enD = enQ;
    cpuD = cpuQ;
    canD = canQ;
    flushD = flushQ;
    drop = 1'b0;
    push = strobeWr && (wrData == cfmp_pkg::STROBE_CODE) && enQ
      && (cntQ != cfmp_pkg::QUEUE_DEPTH);
    pop = txDone && (cntQ != 3'h0);
    if (push)
    begin
      cpuD = cfmp_pkg::ptr_next(cpuQ);
    end
    if (pop)
    begin
      canD = cfmp_pkg::ptr_next(canQ);
    end
    cntD = cntQ + {2'h0, push} - {2'h0, pop};
    if (ctlWr)
    begin
      enD = wrData[cfmp_pkg::F_ENABLE] && mailboxModeSelect && !flushQ;
      if (enQ && !wrData[cfmp_pkg::F_ENABLE])
      begin
        if (txBusy && !(txDone || txStop))
        begin
          flushD = 1'b1;
        end
        else
        begin
          drop = 1'b1;
        end
      end
    end
    if (flushQ && (txDone || txStop))
    begin
      drop = 1'b1;
    end
    if (drop)
    begin
      cntD = 3'h0;
      cpuD = canD;
      flushD = 1'b0;
    end
    pendD = enD && (cntD != 3'h0);
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      enQ <= 1'b0;
      cntQ <= 3'h0;
      cpuQ <= 2'h0;
      canQ <= 2'h0;
      flushQ <= 1'b0;
      pendQ <= 1'b0;
    end
    else
    begin
      enQ <= enD;
      cntQ <= cntD;
      cpuQ <= cpuD;
      canQ <= canD;
      flushQ <= flushD;
      pendQ <= pendD;
    end
  end

  assign statusByte = {cntQ == 3'h0, cntQ == cfmp_pkg::QUEUE_DEPTH, 2'h0, cntQ, enQ};
  assign txQueueEnable = enQ;
  assign txPending = pendQ;
  assign writeSlot = cpuQ;
  assign readSlot = canQ;

endmodule : cfmp_tx_queue
`default_nettype wire
